/* hw/fus_pkg.sv */
// constants, offsets and types of the flash unlock and status register block
package fus_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_WAIT_CONFIG    = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_UNLOCK_KEY     = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_OPTION_KEY     = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS         = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_CONTROL        = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_BOOT_KEY       = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_EVENT_STATUS   = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_EVENT_CLEAR    = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_EVENT_ENABLE   = 8'h38;

  ////////////////////////////////////////////////////////////////////////////
  // key values
  localparam logic [DATA_W-1:0] FIRST_UNLOCK_KEY   = 32'h45670123;
  localparam logic [DATA_W-1:0] SECOND_UNLOCK_KEY  = 32'hCDEF89AB;
  localparam logic [DATA_W-1:0] READ_PROTECT_KEY   = 32'h000000A5;

  ////////////////////////////////////////////////////////////////////////////
  // wait configuration field
  localparam int unsigned WAIT_LSB = 0;
  localparam int unsigned WAIT_W   = 2;
  localparam logic [WAIT_W-1:0] WAIT_ZERO  = 2'h0;
  localparam logic [WAIT_W-1:0] WAIT_ONE   = 2'h1;
  localparam logic [WAIT_W-1:0] WAIT_RESET = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // status field positions
  localparam int unsigned ST_BOOT_LOCK  = 15;
  localparam int unsigned ST_BOOT_SEL   = 14;
  localparam int unsigned ST_DONE       = 5;
  localparam int unsigned ST_VIOLATION  = 4;
  localparam int unsigned ST_BUSY       = 0;
  localparam logic ST_BOOT_SEL_RESET    = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // control field positions
  localparam int unsigned CT_OPT_WE     = 9;
  localparam int unsigned CT_LOCK       = 7;
  localparam int unsigned CT_START      = 6;

  ////////////////////////////////////////////////////////////////////////////
  // event bits, shared by event status, clear and enable
  localparam int unsigned EV_W          = 3;
  localparam int unsigned EV_DONE       = 0;
  localparam int unsigned EV_VIOLATION  = 1;
  localparam int unsigned EV_KEY_FAIL   = 2;
  localparam logic [EV_W-1:0] EV_RESET  = 3'h0;

  typedef enum {
    KS_IDLE,
    KS_FIRST,
    KS_OPEN,
    KS_FAIL
  } fus_key_state_t;

endpackage : fus_pkg

/* hw/fus_key_if.sv */
// carrier between the register front and one key sequence checker
`timescale 1ns/1ps
interface fus_key_if;
  logic        wr_stb;
  logic [31:0] wr_data;
  logic        relock;
  logic        unlocked;
  logic        failed;

  modport checker_end (input wr_stb, input wr_data, input relock,
                       output unlocked, output failed);
  modport owner_end   (output wr_stb, output wr_data, output relock,
                       input unlocked, input failed);
endinterface : fus_key_if

/* hw/fus_key_check.sv */
// two-word key sequence checker with sticky failure
`timescale 1ns/1ps
module fus_key_check
  import fus_pkg::*;
(
  input  wire logic    core_clk,
  input  wire logic    reset_n,
  fus_key_if.checker_end key
);

  fus_key_state_t state_r;
  fus_key_state_t state_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // sequence: first key, then second key; read protect key is harmless
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      KS_IDLE: begin
        if (key.wr_stb) begin
          if (key.wr_data == FIRST_UNLOCK_KEY) begin
            state_nxt = KS_FIRST;
          end else if (key.wr_data != READ_PROTECT_KEY) begin // [R4]
            state_nxt = KS_FAIL;
          end
        end
      end
      KS_FIRST: begin
        if (key.wr_stb) begin
          if (key.wr_data == SECOND_UNLOCK_KEY) begin
            state_nxt = KS_OPEN;
          end else if (key.wr_data != READ_PROTECT_KEY) begin // [R4]
            state_nxt = KS_FAIL;
          end
        end
      end
      KS_OPEN: begin
        if (key.relock) begin
          state_nxt = KS_IDLE;
        end
      end
      KS_FAIL: begin
        state_nxt = KS_FAIL; // [R15]
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_r <= KS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign key.unlocked = (state_r == KS_OPEN);
  assign key.failed   = (state_r == KS_FAIL);

endmodule : fus_key_check

/* hw/fus_top.sv */
// flash unlock keys, wait configuration, status and event registers
//
// Behaviour
// [R1] two-bit wait field: 00 zero, 01 one wait
// [R2] software picks waits by system clock rate
// [R3] write-only controller key port, two unlock words
// [R4] read protect key accepted on key port
// [R5] option key port releases option write enable
// [R6] boot lock blocks area select writes
// [R7] boot lock: write one sets, zero ignored
// [R8] area select picks boot or user, resets 0
// [R9] done flag set on successful operation end
// [R10] done flag cleared by writing one
// [R11] violation flag set on protected target, w1c
// [R12] busy bit mirrors operation in progress
// [R13] software checks start trigger zero first
// [R14] start trigger begins erase, cleared at busy end
// [R15] failed unlock stays locked until reset
// [R16] boot unlock key register releases boot lock
// [R17] reserved bits read zero, writes ignored
`timescale 1ns/1ps
module fus_top
  import fus_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic [DATA_W-1:0] bus_wdata,
  input  wire logic              bus_write,
  input  wire logic              bus_read,
  output logic      [DATA_W-1:0] bus_rdata,
  input  wire logic              op_busy,
  input  wire logic              op_done,
  input  wire logic              op_protect_violation,
  output logic                   start_trigger,
  output logic                   option_write_enable,
  output logic                   controller_locked,
  output logic      [WAIT_W-1:0] wait_state_count,
  output logic                   boot_select,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  logic wr_wait;
  logic wr_unlock;
  logic wr_option;
  logic wr_status;
  logic wr_control;
  logic wr_boot;
  logic wr_ev_clear;
  logic wr_ev_enable;

  assign wr_wait      = bus_write && hit(bus_addr, OFF_WAIT_CONFIG);
  assign wr_unlock    = bus_write && hit(bus_addr, OFF_UNLOCK_KEY);
  assign wr_option    = bus_write && hit(bus_addr, OFF_OPTION_KEY);
  assign wr_status    = bus_write && hit(bus_addr, OFF_STATUS);
  assign wr_control   = bus_write && hit(bus_addr, OFF_CONTROL);
  assign wr_boot      = bus_write && hit(bus_addr, OFF_BOOT_KEY);
  assign wr_ev_clear  = bus_write && hit(bus_addr, OFF_EVENT_CLEAR);
  assign wr_ev_enable = bus_write && hit(bus_addr, OFF_EVENT_ENABLE);

  ////////////////////////////////////////////////////////////////////////////
  // key checkers
  fus_key_if ctl_key ();
  fus_key_if opt_key ();
  fus_key_if boot_key ();

  fus_key_check u_ctl_key (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .key      (ctl_key)
  );

  fus_key_check u_opt_key (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .key      (opt_key)
  );

  fus_key_check u_boot_key (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .key      (boot_key)
  );

  logic ctl_unlocked;
  logic opt_relock;

  assign ctl_unlocked = ctl_key.unlocked;

  // controller key port; relocked by writing one to the lock bit
  assign ctl_key.wr_stb  = wr_unlock; // [R3]
  assign ctl_key.wr_data = bus_wdata;
  assign ctl_key.relock  = wr_control && bus_wdata[CT_LOCK];

  // option keys only count while the controller itself is open
  assign opt_relock      = wr_control && ctl_unlocked && !bus_wdata[CT_OPT_WE];
  assign opt_key.wr_stb  = wr_option && ctl_unlocked; // [R5]
  assign opt_key.wr_data = bus_wdata;
  assign opt_key.relock  = opt_relock || ctl_key.relock || !ctl_unlocked;

  // boot key port; relocked by writing one to the boot lock bit
  assign boot_key.wr_stb  = wr_boot; // [R16]
  assign boot_key.wr_data = bus_wdata;
  assign boot_key.relock  = wr_status && bus_wdata[ST_BOOT_LOCK]; // [R7]

  ////////////////////////////////////////////////////////////////////////////
  // wait configuration; invalid codes are not stored so the flash
  // array never sees an unsupported timing
  logic [WAIT_W-1:0] wait_r;
  logic [WAIT_W-1:0] wait_wr;

  assign wait_wr = bus_wdata[WAIT_LSB +: WAIT_W];

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wait_r <= WAIT_RESET;
    end else if (wr_wait && (wait_wr == WAIT_ZERO || wait_wr == WAIT_ONE)) begin
      wait_r <= wait_wr; // [R1]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // busy mirror and start trigger
  logic busy_r;
  logic start_r;
  logic busy_fall;
  logic start_req;

  assign busy_fall = busy_r && !op_busy;
  assign start_req = wr_control && ctl_unlocked && !busy_r && bus_wdata[CT_START];

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= op_busy; // [R12]
    end
  end

  // start is refused while locked or busy; the end of busy wins over
  // a fresh write in the same cycle
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      start_r <= 1'b0;
    end else if (busy_fall) begin
      start_r <= 1'b0; // [R14]
    end else if (start_req) begin
      start_r <= 1'b1; // [R14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // area select, writable only while the boot lock is open
  logic boot_sel_r;
  logic sel_wr;

  // a write that also relocks sets the boot lock but leaves area select unchanged
  assign sel_wr = wr_status && boot_key.unlocked && !bus_wdata[ST_BOOT_LOCK];

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      boot_sel_r <= ST_BOOT_SEL_RESET; // [R8]
    end else if (sel_wr) begin
      boot_sel_r <= bus_wdata[ST_BOOT_SEL]; // [R6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // done and violation flags; a set in the clearing cycle wins
  logic done_r;
  logic viol_r;
  logic done_clr;
  logic viol_clr;

  assign done_clr = wr_status && bus_wdata[ST_DONE];
  assign viol_clr = wr_status && bus_wdata[ST_VIOLATION];

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      done_r <= 1'b0;
    end else if (op_done) begin
      done_r <= 1'b1; // [R9]
    end else if (done_clr) begin
      done_r <= 1'b0; // [R10]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      viol_r <= 1'b0;
    end else if (op_protect_violation) begin
      viol_r <= 1'b1; // [R11]
    end else if (viol_clr) begin
      viol_r <= 1'b0; // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events: sticky status, write-one clear, enable mask
  logic [EV_W-1:0] ev_stat_r;
  logic [EV_W-1:0] ev_en_r;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic [EV_W-1:0] ev_stat_nxt;
  logic            fail_r;
  logic            any_fail;

  assign any_fail = ctl_key.failed || opt_key.failed || boot_key.failed;

  // failure is one event on the first cycle it is seen
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      fail_r <= 1'b0;
    end else begin
      fail_r <= any_fail;
    end
  end

  always_comb begin
    ev_set               = '0;
    ev_set[EV_DONE]      = op_done;
    ev_set[EV_VIOLATION] = op_protect_violation;
    ev_set[EV_KEY_FAIL]  = any_fail && !fail_r;
  end

  assign ev_clr = wr_ev_clear ? bus_wdata[EV_W-1:0] : '0;

  // irq uses the same next value so it never lags a fresh event
  assign ev_stat_nxt = (ev_stat_r & ~ev_clr) | ev_set;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ev_stat_r <= EV_RESET;
    end else begin
      ev_stat_r <= ev_stat_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ev_en_r <= EV_RESET;
    end else if (wr_ev_enable) begin
      ev_en_r <= bus_wdata[EV_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ev_stat_nxt & ev_en_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path; key ports and unmapped offsets read zero
  logic [DATA_W-1:0] rd_nxt;

  always_comb begin
    rd_nxt = '0; // [R17]
    if (bus_read) begin
      unique case (bus_addr)
        OFF_WAIT_CONFIG: begin
          rd_nxt[WAIT_LSB +: WAIT_W] = wait_r;
        end
        OFF_STATUS: begin
          rd_nxt[ST_BOOT_LOCK] = !boot_key.unlocked; // [R6]
          rd_nxt[ST_BOOT_SEL]  = boot_sel_r;
          rd_nxt[ST_DONE]      = done_r;
          rd_nxt[ST_VIOLATION] = viol_r;
          rd_nxt[ST_BUSY]      = busy_r; // [R12]
        end
        OFF_CONTROL: begin
          rd_nxt[CT_OPT_WE] = opt_key.unlocked;
          rd_nxt[CT_LOCK]   = !ctl_unlocked;
          rd_nxt[CT_START]  = start_r; // [R13]
        end
        OFF_EVENT_STATUS: begin
          rd_nxt[EV_W-1:0] = ev_stat_r;
        end
        OFF_EVENT_ENABLE: begin
          rd_nxt[EV_W-1:0] = ev_en_r;
        end
        default: begin
          rd_nxt = '0; // [R3]
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bus_rdata <= '0;
    end else begin
      bus_rdata <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs; pins lag the internal state by one cycle
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      start_trigger <= 1'b0;
    end else begin
      start_trigger <= start_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      option_write_enable <= 1'b0;
    end else begin
      option_write_enable <= opt_key.unlocked; // [R5]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      controller_locked <= 1'b1;
    end else begin
      controller_locked <= !ctl_unlocked;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wait_state_count <= WAIT_RESET;
    end else begin
      wait_state_count <= wait_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      boot_select <= ST_BOOT_SEL_RESET;
    end else begin
      boot_select <= boot_sel_r;
    end
  end

endmodule : fus_top

/* testbench/fus_top_chk.sv */
// port assertions of the flash unlock and status block
`timescale 1ns/1ps
module fus_top_chk
  import fus_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              reset_n,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_wdata,
  input wire logic              bus_write,
  input wire logic              bus_read,
  input wire logic [DATA_W-1:0] bus_rdata,
  input wire logic              op_busy,
  input wire logic              op_done,
  input wire logic              op_protect_violation,
  input wire logic              start_trigger,
  input wire logic              option_write_enable,
  input wire logic              controller_locked,
  input wire logic [WAIT_W-1:0] wait_state_count,
  input wire logic              boot_select,
  input wire logic              irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic st_rd;
  logic wc_wr;
  assign st_rd = bus_read && bus_addr == OFF_STATUS;
  assign wc_wr = bus_write && bus_addr == OFF_WAIT_CONFIG;
  ////////////////////////////////////////////////////////////////////////////
  a_wait_legal: assert property (wait_state_count[1] == 1'b0)
    else $error("wait code out of range");
  a_wait_store: assert property (wc_wr && !bus_wdata[1] |-> ##2
    wait_state_count == $past(bus_wdata[1:0], 2)) else $error("wait code not stored");
  a_wait_refuse: assert property (wc_wr && bus_wdata[1] |-> ##2
    $stable(wait_state_count)) else $error("invalid wait code stored");
  a_wait_read: assert property (bus_read && bus_addr == OFF_WAIT_CONFIG |=>
    bus_rdata == {30'h0, wait_state_count}) else $error("wait read wrong");
  a_key_read: assert property (bus_read && (bus_addr == OFF_UNLOCK_KEY ||
    bus_addr == OFF_OPTION_KEY) |=> bus_rdata == 32'h0) else $error("key port readable");
  a_rdata_idle: assert property (!$past(bus_read) |-> bus_rdata == 32'h0)
    else $error("read data outside slot");
  a_status_rsvd: assert property (st_rd |=> bus_rdata[31:16] == 16'h0 &&
    bus_rdata[13:6] == 8'h0 && bus_rdata[3:1] == 3'h0) else $error("status reserved set");
  a_busy_read: assert property (st_rd |=> bus_rdata[ST_BUSY] == $past(op_busy, 2))
    else $error("busy bit wrong");
  a_sel_read: assert property (st_rd |=> bus_rdata[ST_BOOT_SEL] == boot_select)
    else $error("area select mismatch");
  a_start_unlock: assert property ($rose(start_trigger) |-> !$past(controller_locked))
    else $error("start while locked");
  a_start_fall: assert property ($fell(start_trigger) |->
    !$past(op_busy, 2) && $past(op_busy, 3)) else $error("start cleared while busy");
  a_opt_unlock: assert property ($rose(option_write_enable) |-> !controller_locked)
    else $error("option enable while locked");
  a_irq_cause: assert property ($rose(irq) |-> $past(op_done) ||
    $past(op_protect_violation) || $past(bus_write) || $past(bus_write, 2))
    else $error("interrupt without cause");
  c_done_read: cover property (st_rd ##1 bus_rdata[ST_DONE]);
  c_irq_rise: cover property ($rose(irq));
  c_start_end: cover property ($fell(start_trigger));
endmodule : fus_top_chk

bind fus_top fus_top_chk i_chk (
  .core_clk(core_clk), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata), .op_busy(op_busy),
  .op_done(op_done), .op_protect_violation(op_protect_violation),
  .start_trigger(start_trigger), .option_write_enable(option_write_enable),
  .controller_locked(controller_locked), .wait_state_count(wait_state_count),
  .boot_select(boot_select), .irq(irq));

/* testbench/fus_top_bench.sv */
// self-checking bench of the flash unlock and status block
`timescale 1ns/1ps
module fus_top_bench
  import fus_pkg::*;
;
  logic              core_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic [ADDR_W-1:0] bus_addr = 8'h00;
  logic [DATA_W-1:0] bus_wdata = 32'h0;
  logic              bus_write = 1'b0;
  logic              bus_read = 1'b0;
  logic              op_busy = 1'b0;
  logic              op_done = 1'b0;
  logic              op_viol = 1'b0;
  logic [DATA_W-1:0] bus_rdata;
  logic              start_trigger;
  logic              opt_we;
  logic              locked;
  logic [WAIT_W-1:0] wait_cnt;
  logic              boot_select;
  logic              irq;
  int                fail_count = 0;
  int                num_checks = 0;
  always #4 core_clk = ~core_clk;
  fus_top i_dut (.core_clk(core_clk), .reset_n(reset_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
    .bus_rdata(bus_rdata), .op_busy(op_busy), .op_done(op_done),
    .op_protect_violation(op_viol), .start_trigger(start_trigger),
    .option_write_enable(opt_we), .controller_locked(locked),
    .wait_state_count(wait_cnt), .boot_select(boot_select), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_write <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge core_clk);
    bus_write <= 1'b0;
  endtask : wr
  task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    bus_read <= 1'b1;
    bus_addr <= a;
    @(posedge core_clk);
    bus_read <= 1'b0;
    #1 cmp(exp, bus_rdata);
  endtask : rdc
  task automatic evt(input logic viol);
    @(posedge core_clk);
    if (viol) op_viol <= 1'b1;
    else op_done <= 1'b1;
    @(posedge core_clk);
    op_viol <= 1'b0;
    op_done <= 1'b0;
  endtask : evt
  task automatic do_reset();
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
  endtask : do_reset
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals();
    rdc(OFF_STATUS, 32'h00008000);
    rdc(OFF_UNLOCK_KEY, 32'h0);
    rdc(OFF_OPTION_KEY, 32'h0);
    rdc(OFF_CONTROL, 32'h00000080);
    rdc(8'h3C, 32'h0);
    cmp(32'(locked), 32'h1);
    cmp(32'(opt_we), 32'h0);
  endtask : t_reset_vals
  task automatic t_wait();
    wr(OFF_WAIT_CONFIG, 32'hFFFFFFFF);
    rdc(OFF_WAIT_CONFIG, 32'h0);
    wr(OFF_WAIT_CONFIG, 32'h1);
    rdc(OFF_WAIT_CONFIG, 32'h1);
    wr(OFF_WAIT_CONFIG, 32'h2);
    rdc(OFF_WAIT_CONFIG, 32'h1);
    cmp(32'(wait_cnt), 32'h1);
    wr(OFF_WAIT_CONFIG, 32'h0);
    tick(2);
    cmp(32'(wait_cnt), 32'h0);
  endtask : t_wait
  task automatic t_boot();
    wr(OFF_STATUS, 32'h00004000);
    rdc(OFF_STATUS, 32'h00008000);
    wr(OFF_BOOT_KEY, FIRST_UNLOCK_KEY);
    wr(OFF_BOOT_KEY, SECOND_UNLOCK_KEY);
    rdc(OFF_STATUS, 32'h0);
    rdc(OFF_BOOT_KEY, 32'h0);
    wr(OFF_STATUS, 32'h00004000);
    rdc(OFF_STATUS, 32'h00004000);
    cmp(32'(boot_select), 32'h1);
    wr(OFF_STATUS, 32'h00008000);
    rdc(OFF_STATUS, 32'h0000C000);
    wr(OFF_STATUS, 32'h0);
    rdc(OFF_STATUS, 32'h0000C000);
  endtask : t_boot
  task automatic t_unlock();
    wr(OFF_CONTROL, 32'h40);
    tick(2);
    cmp(32'(start_trigger), 32'h0);
    wr(OFF_UNLOCK_KEY, READ_PROTECT_KEY);
    wr(OFF_UNLOCK_KEY, FIRST_UNLOCK_KEY);
    wr(OFF_UNLOCK_KEY, SECOND_UNLOCK_KEY);
    tick(2);
    cmp(32'(locked), 32'h0);
    wr(OFF_OPTION_KEY, FIRST_UNLOCK_KEY);
    wr(OFF_OPTION_KEY, SECOND_UNLOCK_KEY);
    tick(2);
    cmp(32'(opt_we), 32'h1);
  endtask : t_unlock
  task automatic t_start();
    // start only issued while it reads zero
    cmp(32'(start_trigger), 32'h0);
    rdc(OFF_CONTROL, 32'h00000200);
    wr(OFF_CONTROL, 32'h240);
    tick(2);
    cmp(32'(start_trigger), 32'h1);
    @(posedge core_clk) op_busy <= 1'b1;
    tick(3);
    rdc(OFF_STATUS, 32'h0000C001);
    cmp(32'(start_trigger), 32'h1);
    @(posedge core_clk) op_busy <= 1'b0;
    tick(4);
    cmp(32'(start_trigger), 32'h0);
    rdc(OFF_STATUS, 32'h0000C000);
    wr(OFF_CONTROL, 32'h0);
    tick(3);
    cmp(32'({locked, opt_we}), 32'h0);
    wr(OFF_CONTROL, 32'h80);
    tick(3);
    cmp(32'({locked, opt_we}), 32'h2);
  endtask : t_start
  task automatic t_events();
    wr(OFF_EVENT_ENABLE, 32'h1);
    evt(1'b0);
    tick(2);
    cmp(32'(irq), 32'h1);
    wr(OFF_STATUS, 32'h0);
    rdc(OFF_STATUS, 32'h0000C020);
    rdc(OFF_EVENT_STATUS, 32'h1);
    wr(OFF_STATUS, 32'h20);
    rdc(OFF_STATUS, 32'h0000C000);
    wr(OFF_EVENT_CLEAR, 32'h1);
    tick(2);
    cmp(32'(irq), 32'h0);
    evt(1'b1);
    tick(2);
    cmp(32'(irq), 32'h0);
    rdc(OFF_STATUS, 32'h0000C010);
    rdc(OFF_EVENT_STATUS, 32'h2);
    wr(OFF_EVENT_ENABLE, 32'h2);
    rdc(OFF_EVENT_ENABLE, 32'h2);
    tick(2);
    cmp(32'(irq), 32'h1);
    wr(OFF_STATUS, 32'h10);
    wr(OFF_EVENT_CLEAR, 32'h2);
    tick(2);
    cmp(32'(irq), 32'h0);
    rdc(OFF_STATUS, 32'h0000C000);
  endtask : t_events
  task automatic t_fail();
    do_reset();
    tick(1);
    cmp(32'(boot_select), 32'h0);
    wr(OFF_UNLOCK_KEY, 32'h12345678);
    wr(OFF_UNLOCK_KEY, FIRST_UNLOCK_KEY);
    wr(OFF_UNLOCK_KEY, SECOND_UNLOCK_KEY);
    tick(2);
    cmp(32'(locked), 32'h1);
    rdc(OFF_EVENT_STATUS, 32'h4);
    wr(OFF_CONTROL, 32'h40);
    tick(2);
    cmp(32'(start_trigger), 32'h0);
  endtask : t_fail
  ////////////////////////////////////////////////////////////////////////////
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    end_sim();
  end
  initial begin
    do_reset();
    t_reset_vals();
    t_wait();
    t_boot();
    t_unlock();
    t_start();
    t_events();
    t_fail();
    end_sim();
  end
endmodule : fus_top_bench
